// ==== hdl/mbus_ctl_consts.vh ====
// constants for the memory bus data and coherency control block
// assumes a 250 MHz core clock and an 8-bit data slice with four parity bits
`ifndef MBUS_CTL_CONSTS_VH
`define MBUS_CTL_CONSTS_VH

// data slice and parity widths
`define DATA_W 8
`define PAR_W 4
`define WORD_W 12
`define BURST_W 3
`define FIFO_DEPTH 32
`define FIFO_AW 5

// core clock period and strap watch window after reset release
`define CLK_PERIOD_NS 4
`define STRAP_WIN_NS 640
`define STRAP_WIN_CYC ((`STRAP_WIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_CNT_W 8
`define STRAP_TAKE_CYC 2

// bit positions inside the synchronised control pin vector
`define PIN_MODE 0
`define PIN_FRZ 1
`define PIN_EOC 2
`define PIN_RDY 3
`define PIN_OCLK 4
`define PIN_SCYC 5
`define PIN_SSTB 6
`define PIN_KEN 7
`define PIN_KWIN 8
`define PIN_RO 9
`define PIN_DOE 10
`define CTL_W 11

// reset values
`define RST_WORD 12'h000
`define RST_BURST 3'h0

`endif

// ==== hdl/mbus_data_ctl.v ====
// memory bus side data path, cycle end, freeze, snoop response and cacheability sampling
// assumes every bus pin is asynchronous to clk; the cache array side runs on clk
`timescale 1ns/10ps
`default_nettype none
`include "mbus_ctl_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk, // core clock
    input wire reset_n, // async reset
    input wire [WIDTH-1:0] in_data, // word to store
    input wire in_valid, // word offered
    output wire in_ready, // room for a word
    output wire [WIDTH-1:0] out_data, // oldest word
    output wire out_valid, // a word is held
    input wire out_ready // oldest word taken
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH);
    assign out_valid = (count != 0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // word_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R01 - data pins float while the output enable pin is high, drive while low
// R02 - output enable acts combinationally, same in strobed and clocked modes
// R03 - four parity pins follow exactly the data pins' sampling and driving
// R04 - cycle end terminates the bus cycle on the memory bus timing
// R05 - cycle end latches or drives data and clears the burst counter
// R06 - freeze low during a write holds that write data against allocation
// R07 - a line allocated after a frozen write goes to the modified state
// R08 - freeze pin sampled at reset release selects data drive strength
// R09 - snoop reports hit to modified and schedules that line's write-back
// R10 - hit-modified valid the cycle after snoop cycle, held until snoop strobe
// R11 - cacheability input sampled only while the cacheability window is asserted
// R12 - output latch clock makes a transparent latch on the data outputs
// R13 - each output strobe edge drives the next word in strobed mode
// R14 - read-only cacheable line skips first level, kept shared in this cache
// R15 - read-only sampled with the window; later writes post to memory
// R16 - strap high at reset means strobed, toggling means clocked
// R17 - clocked mode: each ready advances burst counter and moves a word
// R18 - strobed mode: each input strobe edge latches data and counts
// R19 - clocked mode samples cycle end and freeze on memory clock rise
module mbus_data_ctl (
    input wire clk, // core clock, 250 MHz
    input wire reset_n, // async reset, active low
    input wire strobe_mode_strap, // memory clock, strobe mode strap at reset
    input wire write_freeze_n, // freeze, drive strength strap at reset
    input wire mem_cycle_end_n, // end of memory bus cycle
    input wire mem_ready_n, // ready in clocked mode, input strobe in strobed mode
    input wire output_latch_clock, // output latch clock, output strobe in strobed mode
    input wire mem_data_out_en_n, // data output enable from the controller
    input wire snoop_cycle_n, // snoop cycle indication
    input wire snoop_strobe_n, // snoop strobe
    input wire bus_cacheable_n, // cacheability qualifier
    input wire cacheability_window_n, // window for cacheability sampling
    input wire line_read_only_n, // read-only qualifier
    input wire [`DATA_W-1:0] mem_data_in, // data pins, level seen on the bus
    output reg [`DATA_W-1:0] mem_data_out, // data pins, driven value
    output wire [`DATA_W-1:0] mem_data_oe, // data pins, high while driving
    input wire [`PAR_W-1:0] mem_parity_in, // parity pins, level seen
    output reg [`PAR_W-1:0] mem_parity_out, // parity pins, driven value
    output wire [`PAR_W-1:0] mem_parity_oe, // parity pins, high while driving
    output reg drive_high, // high drive strength selected
    output reg strobed_mode, // bus runs strobed
    output reg clocked_mode, // bus runs clocked
    input wire [`WORD_W-1:0] wr_word, // outgoing word {parity, data}
    input wire wr_valid, // outgoing word offered
    output wire wr_ready, // buffer has room
    output reg [`WORD_W-1:0] rd_word, // incoming word {parity, data}
    output reg rd_valid, // incoming word pulse
    output reg [`BURST_W-1:0] burst_count, // memory burst counter
    output reg cycle_done, // bus cycle ended pulse
    output reg [`WORD_W-1:0] frozen_word, // write data held by freeze
    output reg frozen_valid, // frozen data present
    input wire alloc_done, // line allocation finished pulse
    output reg alloc_modified, // allocated line state is modified
    input wire snoop_lookup_modified, // tag lookup: snooped line is modified
    output reg snoop_hit_modified_n, // hit to modified line, active low
    output reg writeback_req, // write-back scheduling pulse
    output reg l1_cacheable, // first level may cache the line
    output reg l2_cacheable, // this cache may keep the line
    output reg l2_shared, // line kept in shared state
    output reg line_read_only, // sampled read-only
    input wire cpu_write, // write hit to the current line, pulse
    output reg write_update_cache, // write updates cached copy, pulse
    output reg write_post_mem // write posted to memory, pulse
);
    localparam [2:0] MODE_DETECT = 3'b001;
    localparam [2:0] MODE_CLOCKED = 3'b010;
    localparam [2:0] MODE_STROBED = 3'b100;
    localparam [31:0] STRAP_LAST_W = `STRAP_WIN_CYC - 1;
    localparam [31:0] STRAP_TAKE_W = `STRAP_TAKE_CYC;
    localparam [`STRAP_CNT_W-1:0] STRAP_LAST = STRAP_LAST_W[`STRAP_CNT_W-1:0];
    localparam [`STRAP_CNT_W-1:0] STRAP_TAKE = STRAP_TAKE_W[`STRAP_CNT_W-1:0];

    reg [`CTL_W-1:0] ctl_s1;
    reg [`CTL_W-1:0] ctl_s2;
    reg [`CTL_W-1:0] ctl_p;
    reg [`WORD_W-1:0] din_s1;
    reg [`WORD_W-1:0] din_s2;
    reg [2:0] mode;
    reg [`STRAP_CNT_W-1:0] strap_cnt;
    reg strap_toggled;
    reg strap_taken;
    reg [`WORD_W-1:0] stage;
    wire [`WORD_W-1:0] fifo_word;
    wire fifo_valid;
    wire [`CTL_W-1:0] rise;
    wire [`CTL_W-1:0] fall;
    wire driving;
    wire end_cyc;
    wire take_in;
    wire give_out;
    wire latch_open;
    wire frz_now;

    // enable goes straight from pin to drivers, no clock in the path [R01] [R02] [R03]
    assign mem_data_oe = {`DATA_W{~mem_data_out_en_n}};
    assign mem_parity_oe = {`PAR_W{~mem_data_out_en_n}};

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; edges are taken from the second stage only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_s1 <= 11'h7ff;
            ctl_s2 <= 11'h7ff;
            ctl_p <= 11'h7ff;
            din_s1 <= `RST_WORD;
            din_s2 <= `RST_WORD;
        end else begin
            ctl_s1 <= {mem_data_out_en_n, line_read_only_n, cacheability_window_n,
                       bus_cacheable_n, snoop_strobe_n, snoop_cycle_n, output_latch_clock,
                       mem_ready_n, mem_cycle_end_n, write_freeze_n, strobe_mode_strap};
            ctl_s2 <= ctl_s1;
            ctl_p <= ctl_s2;
            din_s1 <= {mem_parity_in, mem_data_in};
            din_s2 <= din_s1;
        end
    end

    assign rise = ctl_s2 & ~ctl_p;
    assign fall = ~ctl_s2 & ctl_p;
    assign driving = ~ctl_s2[`PIN_DOE];

    ////////////////////////////////////////////////////////////////////////////
    // straps: the window after release watches the mode pin for activity;
    // the async reset cannot capture a pin, so a toggle is judged after release
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= MODE_DETECT;
            strap_cnt <= {`STRAP_CNT_W{1'b0}};
            strap_toggled <= 1'b0;
            strap_taken <= 1'b0;
            drive_high <= 1'b0;
        end else begin
            // the pin level at release reaches stage two on the second edge and is taken on the third
            if (!strap_taken && strap_cnt == STRAP_TAKE) begin
                strap_taken <= 1'b1;
                drive_high <= ~ctl_s2[`PIN_FRZ]; // [R08]
            end
            case (mode)
                MODE_DETECT: begin
                    strap_cnt <= strap_cnt + 1'b1;
                    if (rise[`PIN_MODE] | fall[`PIN_MODE]) begin
                        strap_toggled <= 1'b1;
                    end
                    if (strap_cnt == STRAP_LAST) begin
                        if (strap_toggled) begin
                            mode <= MODE_CLOCKED; // [R16]
                        end else if (ctl_s2[`PIN_MODE]) begin
                            mode <= MODE_STROBED; // [R16]
                        end else begin
                            mode <= MODE_CLOCKED;
                        end
                    end
                end
                MODE_CLOCKED: begin
                    mode <= MODE_CLOCKED;
                end
                MODE_STROBED: begin
                    mode <= MODE_STROBED;
                end
                default: begin
                    mode <= MODE_DETECT;
                end
            endcase
        end
    end

    always @* begin
        clocked_mode = mode[1];
        strobed_mode = mode[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus events, clocked on memory clock rise, strobed on strobe edges and the cycle end fall
    assign end_cyc = clocked_mode ? (rise[`PIN_MODE] & ~ctl_s2[`PIN_EOC]) // [R04] [R19]
                   : (strobed_mode & fall[`PIN_EOC]); // [R04]
    assign take_in = ~driving & (clocked_mode
                   ? (rise[`PIN_MODE] & (~ctl_s2[`PIN_RDY] | ~ctl_s2[`PIN_EOC])) // [R17] [R05]
                   : (strobed_mode & (rise[`PIN_RDY] | fall[`PIN_RDY] | end_cyc))); // [R18]
    assign give_out = driving & (clocked_mode
                    ? (rise[`PIN_MODE] & (~ctl_s2[`PIN_RDY] | ~ctl_s2[`PIN_EOC])) // [R17] [R05]
                    : (strobed_mode & (rise[`PIN_OCLK] | fall[`PIN_OCLK] | end_cyc))); // [R13]
    // strobed mode has no latch clock, the strobe itself paces the words
    assign latch_open = strobed_mode | ctl_s2[`PIN_OCLK]; // [R12]
    assign frz_now = ~ctl_s2[`PIN_FRZ] & (clocked_mode ? rise[`PIN_MODE] : strobed_mode); // [R19]

    word_fifo #(
        .WIDTH(`WORD_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) out_buf (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(wr_word),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(give_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // data path: parity rides in the same word as data [R03]
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage <= `RST_WORD;
            mem_data_out <= 8'h00;
            mem_parity_out <= 4'h0;
            rd_word <= `RST_WORD;
            rd_valid <= 1'b0;
            burst_count <= `RST_BURST;
            cycle_done <= 1'b0;
        end else begin
            rd_valid <= take_in;
            cycle_done <= end_cyc;
            if (take_in) begin
                rd_word <= din_s2; // [R03] [R05] [R18]
            end
            if (give_out & fifo_valid) begin
                stage <= fifo_word; // [R05] [R13]
            end
            if (latch_open) begin
                {mem_parity_out, mem_data_out} <= stage; // [R12] [R03]
            end
            if (end_cyc) begin
                burst_count <= `RST_BURST; // [R05]
            end else if (take_in | give_out) begin
                burst_count <= burst_count + 1'b1; // [R17] [R18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // freeze and allocation; a new freeze in the allocation cycle wins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frozen_word <= `RST_WORD;
            frozen_valid <= 1'b0;
            alloc_modified <= 1'b0;
        end else begin
            if (alloc_done) begin
                alloc_modified <= frozen_valid; // [R07]
            end
            if (frz_now & give_out & fifo_valid) begin
                frozen_word <= fifo_word; // [R06]
                frozen_valid <= 1'b1; // [R06]
            end else if (alloc_done) begin
                frozen_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // snoop response and cacheability qualifiers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            snoop_hit_modified_n <= 1'b1;
            writeback_req <= 1'b0;
            l1_cacheable <= 1'b0;
            l2_cacheable <= 1'b0;
            l2_shared <= 1'b0;
            line_read_only <= 1'b0;
            write_update_cache <= 1'b0;
            write_post_mem <= 1'b0;
        end else begin
            writeback_req <= fall[`PIN_SCYC] & snoop_lookup_modified; // [R09]
            if (fall[`PIN_SCYC]) begin
                snoop_hit_modified_n <= ~snoop_lookup_modified; // [R09] [R10]
            end else if (fall[`PIN_SSTB]) begin
                snoop_hit_modified_n <= 1'b1; // [R10]
            end
            if (fall[`PIN_KWIN]) begin
                l2_cacheable <= ~ctl_s2[`PIN_KEN]; // [R11]
                l1_cacheable <= ~ctl_s2[`PIN_KEN] & ctl_s2[`PIN_RO]; // [R14]
                l2_shared <= ~ctl_s2[`PIN_KEN] & ~ctl_s2[`PIN_RO]; // [R14]
                line_read_only <= ~ctl_s2[`PIN_RO]; // [R15]
            end
            write_update_cache <= cpu_write & ~line_read_only; // [R15]
            write_post_mem <= cpu_write & line_read_only; // [R15]
        end
    end
endmodule // mbus_data_ctl
`default_nettype wire

// ==== tb/mbus_data_ctl_props.sv ====
// concurrent checks on the memory bus data control ports
// assumes the shared constants header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "mbus_ctl_consts.vh"
module mbus_data_ctl_props (
    input wire clk, // clock
    input wire reset_n, // reset
    input wire mem_data_out_en_n, // enable
    input wire [`DATA_W-1:0] mem_data_oe, // data oe
    input wire [`PAR_W-1:0] mem_parity_oe, // parity oe
    input wire snoop_cycle_n, // snoop
    input wire snoop_strobe_n, // strobe
    input wire snoop_hit_modified_n, // hit
    input wire writeback_req, // wb
    input wire rd_valid, // word in
    input wire cycle_done, // end
    input wire [`BURST_W-1:0] burst_count, // count
    input wire alloc_done, // alloc
    input wire frozen_valid, // frozen
    input wire alloc_modified, // state
    input wire l1_cacheable, // l1
    input wire l2_cacheable, // l2
    input wire l2_shared, // shared
    input wire line_read_only, // ro
    input wire cpu_write, // write
    input wire write_post_mem, // post
    input wire write_update_cache, // update
    input wire drive_high // strength
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_oe_follow: assert property ({mem_parity_oe, mem_data_oe} == {12{~mem_data_out_en_n}})
        else $error("drive enables differ from enable pin");
    chk_burst_step: assert property (rd_valid && !cycle_done |-> burst_count == $past(burst_count) + 3'h1)
        else $error("burst count did not step");
    chk_cycle_clear: assert property (cycle_done |-> burst_count == 3'h0)
        else $error("burst count not cleared at cycle end");
    // snoop pins pass two sync flops, so the cause lies three samples back
    chk_hit_start: assert property ($fell(snoop_hit_modified_n) |-> !$past(snoop_cycle_n, 3))
        else $error("hit modified without snoop cycle");
    chk_hit_release: assert property ($rose(snoop_hit_modified_n) |-> !$past(snoop_strobe_n, 3))
        else $error("hit modified left before snoop strobe");
    chk_wb_pulse: assert property (writeback_req |-> !snoop_hit_modified_n ##1 !writeback_req)
        else $error("write-back request without modified hit");
    chk_frozen_hold: assert property (frozen_valid && !alloc_done |=> frozen_valid)
        else $error("frozen data lost before allocation");
    chk_alloc_state: assert property (alloc_done |=> alloc_modified == $past(frozen_valid))
        else $error("allocated state not tied to freeze");
    chk_qual_order: assert property ((l1_cacheable || l2_shared) |-> l2_cacheable && (l2_shared == line_read_only))
        else $error("cacheability outputs inconsistent");
    chk_write_route: assert property (cpu_write |=> write_post_mem == $past(line_read_only) && write_update_cache != $past(line_read_only))
        else $error("write routed wrongly for read-only line");
    chk_strap_held: assert property (reset_n && $past(reset_n, 4) |-> $stable(drive_high))
        else $error("drive strength changed after reset");
    cover property (writeback_req);
    cover property (alloc_modified);
    cover property (write_post_mem);
endmodule // mbus_data_ctl_props
bind mbus_data_ctl mbus_data_ctl_props chk_u (
    .clk(clk), .reset_n(reset_n), .mem_data_out_en_n(mem_data_out_en_n),
    .mem_data_oe(mem_data_oe), .mem_parity_oe(mem_parity_oe), .snoop_cycle_n(snoop_cycle_n),
    .snoop_strobe_n(snoop_strobe_n), .snoop_hit_modified_n(snoop_hit_modified_n),
    .writeback_req(writeback_req), .rd_valid(rd_valid), .cycle_done(cycle_done),
    .burst_count(burst_count), .alloc_done(alloc_done), .frozen_valid(frozen_valid),
    .alloc_modified(alloc_modified), .l1_cacheable(l1_cacheable), .l2_cacheable(l2_cacheable),
    .l2_shared(l2_shared), .line_read_only(line_read_only), .cpu_write(cpu_write),
    .write_post_mem(write_post_mem), .write_update_cache(write_update_cache),
    .drive_high(drive_high)
);
`default_nettype wire

// ==== tb/mem_ctl_model.sv ====
// behavioural memory bus controller facing the cache data control block
// assumes the bench calls cycle() once per transferred word
`timescale 1ns/10ps
`default_nettype none
`include "mbus_ctl_consts.vh"
module mem_ctl_model (
    output logic mem_clk, // memory clock, also mode strap
    output logic latch_clk, // skewed output latch clock
    output logic ready_n, // word ready
    output logic cycle_end_n, // end of cycle
    output logic freeze_n, // freeze, strength strap in reset
    output logic out_en_n, // data enable
    input wire logic [`WORD_W-1:0] dev_word, // {parity, data} from device
    output logic [`WORD_W-1:0] bus_word // {parity, data} on the wires
);
    logic [`WORD_W-1:0] drv;
    // clock toggles through reset, so the bus comes up clocked
    initial begin
        mem_clk = 1'b0;
        forever #80 mem_clk = ~mem_clk;
    end
    initial begin
        ready_n = 1'b1;
        cycle_end_n = 1'b1;
        freeze_n = 1'b1;
        out_en_n = 1'b1;
        latch_clk = 1'b0;
        drv = 12'h000;
    end
    always @(mem_clk) latch_clk <= #8 mem_clk;
    // released wires show the inverse of the last word, so stale data cannot match
    assign bus_word = out_en_n ? drv : dev_word;
    // signals change at the clock fall and hold across the next rise
    task automatic cycle(input logic [`WORD_W-1:0] w, input logic wr, input logic last,
                         input logic frz);
        @(negedge mem_clk);
        drv = w;
        out_en_n = ~wr;
        freeze_n = ~frz;
        ready_n = 1'b0;
        cycle_end_n = ~last;
        @(negedge mem_clk);
        ready_n = 1'b1;
        cycle_end_n = 1'b1;
        freeze_n = 1'b1;
        out_en_n = 1'b1;
        drv = ~w;
    endtask
    // holds the shared freeze pin as a strap across a reset
    task automatic hold_freeze(input logic frz);
        freeze_n = ~frz;
    endtask
endmodule // mem_ctl_model
`default_nettype wire

// ==== tb/mbus_data_ctl_test.sv ====
// self-checking bench for the memory bus data control block
// assumes the model drives the bus pins and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
`include "mbus_ctl_consts.vh"
module mbus_data_ctl_test;
    logic clk, reset_n, scyc_n, sstb_n, ken_n, win_n, ro_n, wr_valid, alloc_done, lookup, cpu_write;
    logic [`WORD_W-1:0] wr_word, rd_word, frozen_word;
    logic [`DATA_W-1:0] mem_data_out, mem_data_oe;
    logic [`PAR_W-1:0] mem_parity_out, mem_parity_oe;
    logic [`BURST_W-1:0] burst_count;
    logic drive_high, strobed_mode, clocked_mode, wr_ready, rd_valid, cycle_done, frozen_valid;
    logic alloc_modified, hm_n, writeback_req, l1, l2, sh, ro, upd, post;
    wire logic mclk, lclk, rdy_n, eoc_n, frz_n, en_n;
    wire logic [`WORD_W-1:0] bus_word;
    logic [5:0] rows [4];
    int n_fail = 0, n_checks = 0, wb_cnt = 0, i, k, n_in;
    mbus_data_ctl dut_u (
        .clk(clk), .reset_n(reset_n), .strobe_mode_strap(mclk), .write_freeze_n(frz_n),
        .mem_cycle_end_n(eoc_n), .mem_ready_n(rdy_n), .output_latch_clock(lclk),
        .mem_data_out_en_n(en_n), .snoop_cycle_n(scyc_n), .snoop_strobe_n(sstb_n),
        .bus_cacheable_n(ken_n), .cacheability_window_n(win_n), .line_read_only_n(ro_n),
        .mem_data_in(bus_word[7:0]), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
        .mem_parity_in(bus_word[11:8]), .mem_parity_out(mem_parity_out),
        .mem_parity_oe(mem_parity_oe), .drive_high(drive_high), .strobed_mode(strobed_mode),
        .clocked_mode(clocked_mode), .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_word(rd_word), .rd_valid(rd_valid), .burst_count(burst_count),
        .cycle_done(cycle_done), .frozen_word(frozen_word), .frozen_valid(frozen_valid),
        .alloc_done(alloc_done), .alloc_modified(alloc_modified),
        .snoop_lookup_modified(lookup), .snoop_hit_modified_n(hm_n),
        .writeback_req(writeback_req), .l1_cacheable(l1), .l2_cacheable(l2), .l2_shared(sh),
        .line_read_only(ro), .cpu_write(cpu_write), .write_update_cache(upd),
        .write_post_mem(post)
    );
    mem_ctl_model model_u (
        .mem_clk(mclk), .latch_clk(lclk), .ready_n(rdy_n), .cycle_end_n(eoc_n),
        .freeze_n(frz_n), .out_en_n(en_n), .dev_word({mem_parity_out, mem_data_out}),
        .bus_word(bus_word)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (writeback_req === 1'b1) wb_cnt++;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] pat(input int n);
        return 12'h35c ^ (12'(n) * 12'h111);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_f(input logic [3:0] got, input logic [3:0] exp);
        chk_w({8'h00, got}, {8'h00, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, wr_valid, alloc_done, lookup, cpu_write, wr_word} = '0;
        {scyc_n, sstb_n, ken_n, win_n, ro_n} = 5'h1f;
        // {ken_n, ro_n, l1, l2, shared, read-only}
        rows = '{6'h1c, 6'h07, 6'h30, 6'h21};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        tick(170);
        chk_f({1'b0, strobed_mode, clocked_mode, drive_high}, 4'h2);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            {ken_n, ro_n} <= rows[i][5:4];
            win_n <= 1'b0;
            tick(6);
            chk_f({l1, l2, sh, ro}, rows[i][3:0]);
            @(posedge clk);
            win_n <= 1'b1;
            cpu_write <= 1'b1;
            @(posedge clk);
            cpu_write <= 1'b0;
            #1;
            chk_f({2'b00, post, upd}, {2'b00, rows[i][0], ~rows[i][0]});
            tick(4);
        end
        chk_w({mem_parity_oe, mem_data_oe}, 12'h000);
        for (i = 0; i < 3; i++) begin
            fork
                model_u.cycle(pat(40 + i), 1'b0, i == 2, 1'b0);
                begin
                    for (k = 0; k < 100 && rd_valid !== 1'b1; k++) tick(1);
                    if (k == 100) begin
                        n_fail++;
                    end else begin
                        chk_w(rd_word, pat(40 + i));
                        chk_f({1'b0, burst_count}, (i == 2) ? 4'h0 : 4'(i + 1));
                    end
                end
            join
        end
        // fill while the far side is idle, so nothing leaves the buffer
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_word <= pat(0);
        n_in = 0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (wr_ready === 1'b1) n_in++;
            wr_word <= pat(n_in);
        end
        wr_valid <= 1'b0;
        chk_w(12'(n_in), 12'(`FIFO_DEPTH));
        for (i = 0; i < 33; i++) begin
            model_u.cycle(12'h000, 1'b1, i == 31, i == 5);
            chk_w({mem_parity_out, mem_data_out}, pat((i > 31) ? 31 : i));
            chk_f({1'b0, burst_count}, (i == 31) ? 4'h0 : 4'((i + 1) % 8));
        end
        chk_w(frozen_word, pat(5));
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            alloc_done <= 1'b1;
            @(posedge clk);
            alloc_done <= 1'b0;
            #1;
            chk_f({2'b00, alloc_modified, frozen_valid}, (i == 0) ? 4'h2 : 4'h0);
        end
        for (i = 1; i >= 0; i--) begin
            @(posedge clk);
            lookup <= i[0];
            scyc_n <= 1'b0;
            tick(6);
            chk_f({2'b00, hm_n, wb_cnt[0]}, {2'b00, ~i[0], 1'b1});
            @(posedge clk);
            scyc_n <= 1'b1;
            sstb_n <= 1'b0;
            tick(6);
            chk_f({3'b000, hm_n}, 4'h1);
            @(posedge clk);
            sstb_n <= 1'b1;
            tick(4);
        end
        model_u.hold_freeze(1'b1);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        tick(3);
        chk_f({3'b000, drive_high}, 4'h1);
        results();
    end
endmodule // mbus_data_ctl_test
`default_nettype wire
